// ==== verilog/ieq_pkg.sv ====
// Shared constants and types of the instrument error queue.
// Assumes one clock domain; all event strobes come from logic on that clock.
package ieq_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Sizes and limits.
	localparam int            DEPTH   = 20;        // Queue capacity in entries.
	localparam int            CODE_W  = 16;        // Signed error code width.
	localparam logic [7:0]    HDR_MAX = 8'h0C;     // Longest header element, 12.
	localparam logic [15:0]   EXP_MAX = 16'h7D00;  // Largest exponent, 32000.
	localparam logic [9:0]    DIG_MAX = 10'h0FF;   // Most mantissa digits, 255.
	localparam logic [7:0]    STR_MAX = 8'h0C;     // Longest string parameter, 12.
	localparam logic [6:0]    TXT_LIM = 7'h50;     // Longest message text, 80.

	////////////////////////////////////////////////////////////////////////////
	// Error codes as 16-bit two's complement.
	localparam logic [15:0] C_NOERR = 16'h0000;  // +0
	localparam logic [15:0] C_GET   = 16'hFF97;  // -105
	localparam logic [15:0] C_HLEN  = 16'hFF90;  // -112
	localparam logic [15:0] C_HUND  = 16'hFF8F;  // -113
	localparam logic [15:0] C_NOVF  = 16'hFF85;  // -123
	localparam logic [15:0] C_NDIG  = 16'hFF84;  // -124
	localparam logic [15:0] C_TIGN  = 16'hFF2D;  // -211
	localparam logic [15:0] C_IIGN  = 16'hFF2B;  // -213
	localparam logic [15:0] C_TDLK  = 16'hFF2A;  // -214
	localparam logic [15:0] C_TMD   = 16'hFF21;  // -223
	localparam logic [15:0] C_STALE = 16'hFF1A;  // -230
	localparam logic [15:0] C_OVF   = 16'hFEA2;  // -350
	localparam logic [15:0] C_QINT  = 16'hFE66;  // -410
	localparam logic [15:0] C_QUNT  = 16'hFE5C;  // -420

	////////////////////////////////////////////////////////////////////////////
	// Error sources, lowest index has the highest push priority.
	localparam int NSRC = 13;
	localparam int S_GET = 0, S_HLEN = 1, S_HUND = 2, S_NOVF = 3, S_NDIG = 4;
	localparam int S_TIGN = 5, S_IIGN = 6, S_TDLK = 7, S_TMD = 8, S_STALE = 9;
	localparam int S_QINT = 10, S_QUNT = 11, S_EXT = 12;

	// Event strobes and qualifiers from the command parser and trigger logic.
	typedef struct packed {
		logic        hdrDone;
		logic        hdrKnown;
		logic [7:0]  hdrLen;
		logic        numDone;
		logic [15:0] expMag;
		logic [9:0]  sigDigits;
		logic        strDone;
		logic [7:0]  strLen;
		logic        getRcvd;
		logic        inString;
		logic        trgCmd;
		logic        waitTrig;
		logic        srcBus;
		logic        initCmd;
		logic        measDone;
		logic        devClear;
		logic        readQuery;
		logic        fetchQuery;
		logic        memEmpty;
		logic        dataCmd;
		logic        talkAddr;
		logic        obufDrained;
		logic        clsCmd;
		logic        rstCmd;
		logic        extPush;
		logic [15:0] extCode;
	} ieq_evt_s;

	// One character of the formatted answer.
	typedef struct packed {
		logic       valid;
		logic       last;
		logic [7:0] ch;
	} ieq_resp_s;

	// Message text, right-justified, len characters long.
	typedef struct packed {
		logic [6:0]   len;
		logic [255:0] str;
	} ieq_text_s;

	function automatic ieq_text_s ieq_mk(input logic [6:0] len, input logic [255:0] str);
		ieq_mk = '{len: len, str: str};
	endfunction : ieq_mk

	// Maps a code to its text; unknown codes get a generic text.
	function automatic ieq_text_s ieq_text(input logic [15:0] code);
		unique case (code)
			C_NOERR: ieq_text = ieq_mk(7'h08, "No error");
			C_GET:   ieq_text = ieq_mk(7'h0F, "GET not allowed");
			C_HLEN:  ieq_text = ieq_mk(7'h19, "Program mnemonic too long");
			C_HUND:  ieq_text = ieq_mk(7'h10, "Undefined header");
			C_NOVF:  ieq_text = ieq_mk(7'h10, "Numeric overflow");
			C_NDIG:  ieq_text = ieq_mk(7'h0F, "Too many digits");
			C_TIGN:  ieq_text = ieq_mk(7'h0F, "Trigger ignored");
			C_IIGN:  ieq_text = ieq_mk(7'h0C, "Init ignored");
			C_TDLK:  ieq_text = ieq_mk(7'h10, "Trigger deadlock");
			C_TMD:   ieq_text = ieq_mk(7'h0D, "Too much data");
			C_STALE: ieq_text = ieq_mk(7'h0A, "Data stale");
			C_OVF:   ieq_text = ieq_mk(7'h0F, "Too many errors");
			C_QINT:  ieq_text = ieq_mk(7'h11, "Query INTERRUPTED");
			C_QUNT:  ieq_text = ieq_mk(7'h12, "Query UNTERMINATED");
			default: ieq_text = ieq_mk(7'h0C, "Device error");
		endcase
	endfunction : ieq_text

endpackage : ieq_pkg

// ==== verilog/ieq_mem.sv ====
// Small storage array for the error queue entries.
// Read data come from a register one cycle after rdEn; a read and a write
// to the same address in one cycle return the old word.
`timescale 1ns/1ps
module ieq_mem #(
	parameter int DEPTH = 20,
	parameter int AW    = 5,
	parameter int DW    = 16
) (
	input  wire logic          clk,
	input  wire logic          wrEn,
	input  wire logic [AW-1:0] wrAddr,
	input  wire logic [DW-1:0] wrData,
	input  wire logic          rdEn,
	input  wire logic [AW-1:0] rdAddr,
	output logic      [DW-1:0] rdData
);

	logic [DW-1:0] mem [DEPTH];

	// Contents need no reset: occupancy is tracked by the owner.
	always_ff @(posedge clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
		if (rdEn) begin
			rdData <= mem[rdAddr];
		end
	end

endmodule : ieq_mem

// ==== verilog/ieq_top.sv ====
// Error queue of the remote command interface: detection, queue, answer.
// Assumes all inputs come from logic on sys_clk, so none is synchronised.
//
// Contract
// - Answers come out oldest entry first.
// - Error lamp on while queue holds entries.
// - One beep pulse per generated error.
// - Overflow replaces newest entry with too-many-errors.
// - After overflow, drop errors until a read.
// - Empty read answers +0 No error, unchanged.
// - Power-up and clear-status empty the queue.
// - Reset command leaves the queue alone.
// - Menu off after error level clears queue.
// - Each query pops one formatted entry.
// - Header element over 12 characters logs -112.
// - Unknown header logs -113.
// - Exponent above 32000 logs -123.
// - Over 255 significant digits logs -124.
// - Trigger inside command string logs -105.
// - Unexpected bus trigger logs -211.
// - Initiate while running refused, logs -213.
// - Read query with bus trigger logs -214.
// - String over 12 characters refused, logs -223.
// - Fetch with empty memory logs -230.
// - Data command on held output logs -410.
// - Talk with empty output logs -420.
`timescale 1ns/1ps
module ieq_top #(
	parameter int DEPTH = ieq_pkg::DEPTH,
	parameter int AW    = $clog2(DEPTH),
	parameter int CW    = $clog2(DEPTH + 1)
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire ieq_pkg::ieq_evt_s evt,
	input  wire logic             errQuery,
	input  wire logic             menuErrLevel,
	input  wire logic             menuOff,
	output ieq_pkg::ieq_resp_s    resp,
	output logic                  errLamp,
	output logic                  beep,
	output logic      [CW-1:0]    errCount,
	output logic                  measRunning,
	output logic                  initAccept,
	output logic                  strAccept,
	output logic                  dataAccept,
	output logic                  obufHeld
);

	localparam int            NS   = ieq_pkg::NSRC;
	localparam logic [CW-1:0] FULL = CW'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	typedef enum logic [7:0] {
		ST_IDLE  = 8'h01,
		ST_FETCH = 8'h02,
		ST_SIGN  = 8'h04,
		ST_DIG   = 8'h08,
		ST_COMMA = 8'h10,
		ST_OPEN  = 8'h20,
		ST_TEXT  = 8'h40,
		ST_CLOSE = 8'h80
	} ieq_state_e;

	// Ring pointer step, wrapping at the capacity.
	function automatic logic [AW-1:0] ptrNext(input logic [AW-1:0] p);
		ptrNext = (p == LAST) ? '0 : AW'(p + 1'b1);
	endfunction : ptrNext

	function automatic logic [AW-1:0] ptrPrev(input logic [AW-1:0] p);
		ptrPrev = (p == '0) ? LAST : AW'(p - 1'b1);
	endfunction : ptrPrev

	////////////////////////////////////////////////////////////////////////////
	// State.
	logic [NS-1:0] pend_q;
	logic [NS-1:0] pend_d;
	logic [15:0]   extCode_q;
	logic [AW-1:0] wrPtr_q;
	logic [AW-1:0] wrPtr_d;
	logic [AW-1:0] rdPtr_q;
	logic [AW-1:0] rdPtr_d;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic          lock_q;
	logic          lock_d;
	logic          menuSeen_q;
	logic          measRun_q;
	logic          obuf_q;
	ieq_state_e    st_q;
	ieq_state_e    st_d;
	logic [15:0]   code_q;
	logic [15:0]   code_d;
	logic [1:0]    digIdx_q;
	logic [1:0]    digIdx_d;
	logic [6:0]    txtIdx_q;
	logic [6:0]    txtIdx_d;
	ieq_pkg::ieq_resp_s respD;
	logic [15:0]   rdData;

	////////////////////////////////////////////////////////////////////////////
	// Error detection from parser and trigger events.
	logic [NS-1:0] detect;
	logic          busTrig;
	logic          initOk;
	logic          strOk;
	logic          dataOk;

	assign busTrig = (evt.getRcvd && !evt.inString) || evt.trgCmd;
	assign detect[ieq_pkg::S_GET]   = evt.getRcvd && evt.inString;
	assign detect[ieq_pkg::S_HLEN]  = evt.hdrDone && (evt.hdrLen > ieq_pkg::HDR_MAX);
	assign detect[ieq_pkg::S_HUND]  = evt.hdrDone && !evt.hdrKnown;
	assign detect[ieq_pkg::S_NOVF]  = evt.numDone && (evt.expMag > ieq_pkg::EXP_MAX);
	assign detect[ieq_pkg::S_NDIG]  = evt.numDone
		&& (evt.sigDigits > ieq_pkg::DIG_MAX);
	assign detect[ieq_pkg::S_TIGN]  = busTrig && (!evt.waitTrig || !evt.srcBus);
	assign detect[ieq_pkg::S_IIGN]  = evt.initCmd && measRun_q;
	assign detect[ieq_pkg::S_TDLK]  = evt.readQuery && evt.srcBus;
	assign detect[ieq_pkg::S_TMD]   = evt.strDone && (evt.strLen > ieq_pkg::STR_MAX);
	assign detect[ieq_pkg::S_STALE] = evt.fetchQuery && evt.memEmpty;
	assign detect[ieq_pkg::S_QINT]  = evt.dataCmd && obuf_q;
	assign detect[ieq_pkg::S_QUNT]  = evt.talkAddr && !obuf_q;
	assign detect[ieq_pkg::S_EXT]   = evt.extPush;

	// Commands that are refused do not get their accept strobe.
	assign initOk = evt.initCmd && !measRun_q;
	assign strOk  = evt.strDone && !detect[ieq_pkg::S_TMD];
	assign dataOk = evt.dataCmd && !obuf_q;

	////////////////////////////////////////////////////////////////////////////
	// Pending errors: several may fire in one cycle, one is pushed per cycle.
	logic [NS-1:0] pick;
	logic [15:0]   pickCode;
	logic          takeEn;
	logic          clrQ;

	assign pick   = pend_q & NS'(~pend_q + 1'b1);
	assign takeEn = (|pend_q) && !clrQ;
	// New detections win over the clearing of the entry being taken.
	assign pend_d = (pend_q & ~(takeEn ? pick : '0)) | detect;

	// One-hot source to code selection, one term per source.
	logic [15:0] codeTerm [NS];
	generate
		for (genvar i = 0; i < NS; i++) begin : g_code
			logic [15:0] srcCode;
			assign srcCode = (i == ieq_pkg::S_GET)   ? ieq_pkg::C_GET   :
			                 (i == ieq_pkg::S_HLEN)  ? ieq_pkg::C_HLEN  :
			                 (i == ieq_pkg::S_HUND)  ? ieq_pkg::C_HUND  :
			                 (i == ieq_pkg::S_NOVF)  ? ieq_pkg::C_NOVF  :
			                 (i == ieq_pkg::S_NDIG)  ? ieq_pkg::C_NDIG  :
			                 (i == ieq_pkg::S_TIGN)  ? ieq_pkg::C_TIGN  :
			                 (i == ieq_pkg::S_IIGN)  ? ieq_pkg::C_IIGN  :
			                 (i == ieq_pkg::S_TDLK)  ? ieq_pkg::C_TDLK  :
			                 (i == ieq_pkg::S_TMD)   ? ieq_pkg::C_TMD   :
			                 (i == ieq_pkg::S_STALE) ? ieq_pkg::C_STALE :
			                 (i == ieq_pkg::S_QINT)  ? ieq_pkg::C_QINT  :
			                 (i == ieq_pkg::S_QUNT)  ? ieq_pkg::C_QUNT  : extCode_q;
			if (i == 0) begin : g_first
				assign codeTerm[i] = pick[i] ? srcCode : '0;
			end else begin : g_rest
				assign codeTerm[i] = codeTerm[i-1] | (pick[i] ? srcCode : '0);
			end
		end
	endgenerate
	assign pickCode = codeTerm[NS-1];

	////////////////////////////////////////////////////////////////////////////
	// Queue bookkeeping.
	logic          qAccept;
	logic          popEn;
	logic          lockEff;
	logic [CW-1:0] cntEff;
	logic          storeEn;
	logic          ovfEn;
	logic          wrEn;
	logic [AW-1:0] wrAddr;
	logic [15:0]   wrData;

	// Clear-status and the menu clear empty it; the reset command does not.
	assign clrQ    = evt.clsCmd || (menuOff && menuSeen_q);
	assign qAccept = errQuery && (st_q == ST_IDLE);
	assign popEn   = qAccept && (cnt_q != '0) && !clrQ;
	// A read in the same cycle frees a slot before the push is placed.
	assign lockEff = lock_q && !popEn;
	assign cntEff  = CW'(cnt_q - popEn);
	assign storeEn = takeEn && !lockEff && (cntEff < FULL);
	assign ovfEn   = takeEn && !lockEff && (cntEff == FULL);
	assign wrEn    = storeEn || ovfEn;
	assign wrAddr  = ovfEn ? ptrPrev(wrPtr_q) : wrPtr_q;
	assign wrData  = ovfEn ? ieq_pkg::C_OVF : pickCode;

	assign cnt_d   = clrQ ? '0 : CW'(cntEff + storeEn);
	assign wrPtr_d = clrQ ? '0 : (storeEn ? ptrNext(wrPtr_q) : wrPtr_q);
	assign rdPtr_d = clrQ ? '0 : (popEn ? ptrNext(rdPtr_q) : rdPtr_q);
	assign lock_d  = clrQ ? 1'b0 : (ovfEn || lockEff);

	ieq_mem #(
		.DEPTH (DEPTH),
		.AW    (AW),
		.DW    (ieq_pkg::CODE_W)
	) u_mem (
		.clk    (sys_clk),
		.wrEn   (wrEn),
		.wrAddr (wrAddr),
		.wrData (wrData),
		.rdEn   (popEn),
		.rdAddr (rdPtr_q),
		.rdData (rdData)
	);

	////////////////////////////////////////////////////////////////////////////
	// Answer formatting: sign, decimal digits, comma, quoted text.
	logic [15:0]   mag;
	logic [9:0]    mag10;
	logic [3:0]    dHun;
	logic [3:0]    dTen;
	logic [3:0]    dOne;
	logic [3:0]    digSel;
	logic [1:0]    digTop;
	ieq_pkg::ieq_text_s txt;
	logic [6:0]    txtLen;
	logic [7:0]    txtPos;
	logic [255:0]  txtSh;

	// Codes are assumed below 1000 in magnitude; higher digits are lost.
	assign mag    = code_q[15] ? 16'(~code_q + 1'b1) : code_q;
	assign mag10  = mag[9:0];
	assign dHun   = 4'(mag10 / 10'h064);
	assign dTen   = 4'((mag10 / 10'h00A) % 10'h00A);
	assign dOne   = 4'(mag10 % 10'h00A);
	assign digTop = (mag10 >= 10'h064) ? 2'h2 : ((mag10 >= 10'h00A) ? 2'h1 : 2'h0);
	assign digSel = (digIdx_q == 2'h2) ? dHun : ((digIdx_q == 2'h1) ? dTen : dOne);
	assign txt    = ieq_pkg::ieq_text(code_q);
	assign txtLen = (txt.len > ieq_pkg::TXT_LIM) ? ieq_pkg::TXT_LIM : txt.len;
	assign txtPos = 8'(txtLen - txtIdx_q - 1'b1);
	assign txtSh  = txt.str >> {txtPos, 3'h0};

	// Sequencer, one character per cycle.
	always_comb begin
		st_d     = st_q;
		code_d   = code_q;
		digIdx_d = digIdx_q;
		txtIdx_d = txtIdx_q;
		respD    = '0;
		unique case (st_q)
			ST_IDLE: begin
				if (qAccept) begin
					// Empty queue answers the zero code without touching it.
					code_d = ieq_pkg::C_NOERR;
					st_d   = popEn ? ST_FETCH : ST_SIGN;
				end
			end
			ST_FETCH: begin
				code_d = rdData;
				st_d   = ST_SIGN;
			end
			ST_SIGN: begin
				respD    = '{valid: 1'b1, last: 1'b0, ch: code_q[15] ? 8'h2D : 8'h2B};
				digIdx_d = digTop;
				st_d     = ST_DIG;
			end
			ST_DIG: begin
				respD    = '{valid: 1'b1, last: 1'b0, ch: {4'h3, digSel}};
				digIdx_d = 2'(digIdx_q - 1'b1);
				st_d     = (digIdx_q == 2'h0) ? ST_COMMA : ST_DIG;
			end
			ST_COMMA: begin
				respD = '{valid: 1'b1, last: 1'b0, ch: 8'h2C};
				st_d  = ST_OPEN;
			end
			ST_OPEN: begin
				respD    = '{valid: 1'b1, last: 1'b0, ch: 8'h22};
				txtIdx_d = '0;
				st_d     = ST_TEXT;
			end
			ST_TEXT: begin
				respD    = '{valid: 1'b1, last: 1'b0, ch: txtSh[7:0]};
				txtIdx_d = 7'(txtIdx_q + 1'b1);
				st_d     = (txtIdx_q == 7'(txtLen - 1'b1)) ? ST_CLOSE : ST_TEXT;
			end
			ST_CLOSE: begin
				respD = '{valid: 1'b1, last: 1'b1, ch: 8'h22};
				st_d  = ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Queue and pending registers; power-up reset empties everything.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pend_q  <= '0;
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			cnt_q   <= '0;
			lock_q  <= 1'b0;
		end else begin
			pend_q  <= pend_d;
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
			cnt_q   <= cnt_d;
			lock_q  <= lock_d;
		end
	end

	// The last external code is kept until its entry is pushed.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			extCode_q <= '0;
		end else if (evt.extPush) begin
			extCode_q <= evt.extCode;
		end
	end

	// Menu tracking, measurement state and output-buffer occupancy.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			menuSeen_q <= 1'b0;
			measRun_q  <= 1'b0;
			obuf_q     <= 1'b0;
		end else begin
			menuSeen_q <= menuErrLevel || (menuSeen_q && !menuOff);
			// Device clear halts a measurement and returns to idle.
			measRun_q  <= initOk || (measRun_q && !evt.measDone && !evt.devClear);
			// Held data survive later data commands; reset or drain frees them.
			obuf_q     <= dataOk || (obuf_q && !evt.rstCmd && !evt.obufDrained);
		end
	end

	// Answer sequencer registers.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_q     <= ST_IDLE;
			code_q   <= '0;
			digIdx_q <= '0;
			txtIdx_q <= '0;
		end else begin
			st_q     <= st_d;
			code_q   <= code_d;
			digIdx_q <= digIdx_d;
			txtIdx_q <= txtIdx_d;
		end
	end

	// All outputs are registered.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			resp        <= '0;
			errLamp     <= 1'b0;
			beep        <= 1'b0;
			errCount    <= '0;
			measRunning <= 1'b0;
			initAccept  <= 1'b0;
			strAccept   <= 1'b0;
			dataAccept  <= 1'b0;
			obufHeld    <= 1'b0;
		end else begin
			resp        <= respD;
			errLamp     <= (cnt_d != '0);
			beep        <= takeEn;
			errCount    <= cnt_d;
			measRunning <= initOk || (measRun_q && !evt.measDone && !evt.devClear);
			initAccept  <= initOk;
			strAccept   <= strOk;
			dataAccept  <= dataOk;
			obufHeld    <= dataOk || (obuf_q && !evt.rstCmd && !evt.obufDrained);
		end
	end

endmodule : ieq_top

// ==== test/ieq_checker.sv ====
// Concurrent checks on the error queue top ports.
// Assumes one clock, sys_clk, and the synchronous reset rst.
`timescale 1ns/1ps
module ieq_checker #(
	parameter int DEPTH = 20,
	parameter int CW    = 5
) (
	input wire logic               sys_clk,
	input wire logic               rst,
	input wire ieq_pkg::ieq_evt_s  evt,
	input wire logic               errQuery,
	input wire logic               menuOff,
	input wire logic               errLamp,
	input wire logic               beep,
	input wire logic      [CW-1:0] errCount,
	input wire logic               measRunning,
	input wire logic               initAccept,
	input wire logic               strAccept,
	input wire logic               dataAccept,
	input wire logic               obufHeld
);
	////////////////////////////////////////////////////////////////////////////
	// All checks share the one clock and its reset.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// A long header is a detection; only one pending error, S_GET, may queue ahead of it.
	sequence sHdrLong;
		evt.hdrDone && evt.hdrLen > ieq_pkg::HDR_MAX;
	endsequence
	sequence sBeepSoon;
		##[1:14] beep;
	endsequence

	chk_hdr_beep: assert property (sHdrLong |-> sBeepSoon)
		else $error("long header gave no beep");
	chk_lamp_count: assert property (errLamp == (errCount != '0))
		else $error("lamp disagrees with count");
	chk_count_max: assert property (errCount <= DEPTH)
		else $error("count above capacity");
	chk_init_refuse: assert property (evt.initCmd && measRunning |=> !initAccept)
		else $error("initiate accepted while running");
	chk_str_refuse: assert property (evt.strDone && evt.strLen > ieq_pkg::STR_MAX |=> !strAccept)
		else $error("long string accepted");
	chk_data_keep: assert property (evt.dataCmd && obufHeld && !evt.rstCmd && !evt.obufDrained
		|=> obufHeld && !dataAccept)
		else $error("held output was overwritten");
	chk_cls_empty: assert property (evt.clsCmd |=> errCount == '0)
		else $error("clear status left entries");
	chk_dev_idle: assert property (evt.devClear && !evt.initCmd |=> !measRunning)
		else $error("device clear left measurement running");
	chk_rst_keep: assert property (evt.rstCmd && !evt.clsCmd && !menuOff && !errQuery
		&& !$past(errQuery) |=> errCount >= $past(errCount))
		else $error("reset command removed entries");
endmodule : ieq_checker

bind ieq_top ieq_checker #(.DEPTH(DEPTH), .CW(CW)) chk_u (.sys_clk(sys_clk), .rst(rst),
	.evt(evt), .errQuery(errQuery), .menuOff(menuOff), .errLamp(errLamp), .beep(beep),
	.errCount(errCount), .measRunning(measRunning), .initAccept(initAccept),
	.strAccept(strAccept), .dataAccept(dataAccept), .obufHeld(obufHeld));

// ==== test/ieq_host.sv ====
// Host model: listens to the answer stream and decodes code and text length.
// Assumes one answer at a time, sign first and closing quote flagged last.
`timescale 1ns/1ps
module ieq_host (
	input wire logic               sys_clk,
	input wire logic               rst,
	input wire ieq_pkg::ieq_resp_s resp,
	output logic          [15:0]   code,
	output logic          [6:0]    txtLen,
	output logic                   done
);
	logic [1:0]  stage;
	logic        neg;
	logic [15:0] acc;

	// Stages: sign, digits up to the comma, opening quote, text; done on last.
	always @(posedge sys_clk) begin
		done <= 1'b0;
		if (rst)
			stage <= 2'h0;
		else if (resp.valid) begin
			if (stage == 2'h0) begin
				neg   <= (resp.ch == 8'h2D);
				acc   <= 16'h0000;
				stage <= 2'h1;
			end else if (stage == 2'h1) begin
				if (resp.ch == 8'h2C)
					stage <= 2'h2;
				else
					acc <= acc * 16'h000A + {8'h00, resp.ch} - 16'h0030;
			end else if (stage == 2'h2) begin
				stage  <= 2'h3;
				txtLen <= 7'h00;
			end else if (!resp.last)
				txtLen <= txtLen + 7'h01;
			if (resp.last) begin
				stage <= 2'h0;
				done  <= 1'b1;
			end
		end
	end

	// The code is sign and magnitude turned into two's complement.
	assign code = neg ? 16'h0000 - acc : acc;
endmodule : ieq_host

// ==== test/ieq_top_tb_top.sv ====
// Self-checking bench of the error queue with the host model on its answer port.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
module ieq_top_tb_top;
	logic               sys_clk, rst, errQuery, menuErrLevel, menuOff;
	ieq_pkg::ieq_evt_s  evt;
	ieq_pkg::ieq_resp_s resp;
	logic               errLamp, beep, measRunning, initAccept, strAccept, dataAccept, obufHeld;
	logic [4:0]         errCount;
	logic [15:0]        hCode;
	logic [6:0]         hLen;
	logic               done;
	int                 fail_count, checked, beeps;

	ieq_top dut_u (.sys_clk(sys_clk), .rst(rst), .evt(evt), .errQuery(errQuery),
		.menuErrLevel(menuErrLevel), .menuOff(menuOff), .resp(resp), .errLamp(errLamp),
		.beep(beep), .errCount(errCount), .measRunning(measRunning),
		.initAccept(initAccept), .strAccept(strAccept), .dataAccept(dataAccept),
		.obufHeld(obufHeld));
	ieq_host host_u (.sys_clk(sys_clk), .rst(rst), .resp(resp), .code(hCode),
		.txtLen(hLen), .done(done));

	////////////////////////////////////////////////////////////////////////////
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		if (got !== exp)
			fail_count++;
	endtask : cmp

	// One strobe for one cycle; the host never sends a trigger mid-string on its own.
	task automatic ev(input int k, input logic [15:0] c);
		@(negedge sys_clk);
		case (k)
			0: begin evt.getRcvd = 1'b1; evt.inString = 1'b1; end
			1: begin evt.hdrDone = 1'b1; evt.hdrKnown = 1'b1; evt.hdrLen = 8'h0D; end
			2: evt.hdrDone = 1'b1;
			3: begin evt.numDone = 1'b1; evt.expMag = 16'h7D01; end
			4: begin evt.numDone = 1'b1; evt.sigDigits = 10'h100; end
			5: evt.trgCmd = 1'b1;
			6: evt.initCmd = 1'b1;
			7: begin evt.readQuery = 1'b1; evt.srcBus = 1'b1; end
			8: begin evt.strDone = 1'b1; evt.strLen = 8'h0D; end
			9: begin evt.fetchQuery = 1'b1; evt.memEmpty = 1'b1; end
			10: evt.talkAddr = 1'b1;
			11: evt.dataCmd = 1'b1;
			12: begin evt.strDone = 1'b1; evt.strLen = 8'h0C; evt.hdrDone = 1'b1;
				evt.hdrKnown = 1'b1; evt.hdrLen = 8'h0C; end
			13: begin evt.extPush = 1'b1; evt.extCode = c; end
			14: evt.clsCmd = 1'b1;
			15: evt.rstCmd = 1'b1;
			16: menuErrLevel = 1'b1;
			17: menuOff = 1'b1;
			default: evt.devClear = 1'b1;
		endcase
		@(negedge sys_clk);
		evt = '0;
		menuErrLevel = 1'b0;
		menuOff = 1'b0;
	endtask : ev

	// Asks for one entry; a nonzero p is detected one cycle ahead so that its
	// push is taken at the very edge that also takes the query.
	task automatic query(input logic [15:0] p, output logic [15:0] c, output logic [6:0] n);
		int i;
		@(negedge sys_clk);
		if (p != 16'h0000) begin
			evt.extPush = 1'b1;
			evt.extCode = p;
			@(negedge sys_clk);
			evt = '0;
		end
		errQuery = 1'b1;
		@(negedge sys_clk);
		errQuery = 1'b0;
		for (i = 0; i < 200 && done !== 1'b1; i++)
			@(negedge sys_clk);
		cmp({15'h0, done}, 16'h0001);
		c = hCode;
		n = hLen;
	endtask : query

	////////////////////////////////////////////////////////////////////////////
	task automatic t_empty;
		logic [15:0] c;
		logic [6:0]  n;
		query(16'h0000, c, n);
		cmp(c, ieq_pkg::C_NOERR);
		cmp({9'h0, n}, 16'h0008);
		cmp({11'h0, errCount}, 16'h0000);
	endtask : t_empty

	// Every detector except the external push fires once, with both length limits hit exactly.
	task automatic t_codes;
		logic [15:0] c;
		logic [6:0]  n;
		int          ks[15] = '{0, 1, 2, 3, 4, 5, 6, 6, 7, 8, 9, 10, 11, 11, 12};
		logic [15:0] ex[12] = '{ieq_pkg::C_GET, ieq_pkg::C_HLEN, ieq_pkg::C_HUND,
			ieq_pkg::C_NOVF, ieq_pkg::C_NDIG, ieq_pkg::C_TIGN, ieq_pkg::C_IIGN,
			ieq_pkg::C_TDLK, ieq_pkg::C_TMD, ieq_pkg::C_STALE, ieq_pkg::C_QUNT,
			ieq_pkg::C_QINT};
		beeps = 0;
		foreach (ks[j]) ev(ks[j], 16'h0000);
		repeat (20) @(negedge sys_clk);
		cmp(16'(beeps), 16'h000C);
		cmp({11'h0, errCount}, 16'h000C);
		cmp({15'h0, errLamp}, 16'h0001);
		foreach (ex[j]) begin
			query(16'h0000, c, n);
			cmp(c, ex[j]);
		end
		cmp({15'h0, errLamp}, 16'h0000);
	endtask : t_codes

	// Fill past capacity, then pop while pushing in the same cycle.
	task automatic t_overflow;
		logic [15:0] c;
		logic [6:0]  n;
		beeps = 0;
		for (int i = 1; i <= 22; i++) ev(13, 16'(i));
		repeat (5) @(negedge sys_clk);
		cmp({11'h0, errCount}, 16'h0014);
		cmp(16'(beeps), 16'h0016);
		query(16'h0063, c, n);
		cmp(c, 16'h0001);
		cmp({11'h0, errCount}, 16'h0014);
		for (int i = 2; i <= 19; i++) begin
			query(16'h0000, c, n);
			cmp(c, 16'(i));
		end
		query(16'h0000, c, n);
		cmp(c, ieq_pkg::C_OVF);
		query(16'h0000, c, n);
		cmp(c, 16'h0063);
		cmp({11'h0, errCount}, 16'h0000);
	endtask : t_overflow

	task automatic t_clear;
		ev(13, 16'h0005);
		ev(13, 16'h0006);
		ev(15, 16'h0000);
		ev(18, 16'h0000);
		cmp({11'h0, errCount}, 16'h0002);
		cmp({14'h0, measRunning, obufHeld}, 16'h0000);
		ev(14, 16'h0000);
		cmp({11'h0, errCount}, 16'h0000);
		ev(13, 16'h0007);
		ev(16, 16'h0000);
		cmp({11'h0, errCount}, 16'h0001);
		ev(17, 16'h0000);
		cmp({11'h0, errCount}, 16'h0000);
		// Commands that are not refused must show their accept pulse.
		ev(6, 16'h0000);
		cmp({15'h0, initAccept}, 16'h0001);
		ev(11, 16'h0000);
		cmp({15'h0, dataAccept}, 16'h0001);
		ev(12, 16'h0000);
		cmp({15'h0, strAccept}, 16'h0001);
	endtask : t_clear

	////////////////////////////////////////////////////////////////////////////
	task automatic results;
		$display("checked=%0d fail_count=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results

	// Beep cycles are counted where the register has settled.
	always @(negedge sys_clk) begin
		if (beep === 1'b1)
			beeps++;
	end

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// The scenarios need about 1000 cycles; the watchdog allows twenty times that.
	initial begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		results();
	end

	initial begin
		rst = 1'b1;
		evt = '0;
		errQuery = 1'b0;
		menuErrLevel = 1'b0;
		menuOff = 1'b0;
		fail_count = 0;
		checked = 0;
		beeps = 0;
		repeat (10) @(negedge sys_clk);
		rst = 1'b0;
		t_empty();
		t_codes();
		t_overflow();
		t_clear();
		results();
	end
endmodule : ieq_top_tb_top
